/* File: src/dpsc_core.sv */
// Command interpreter of the digipot serial core: decode, settings and slots.
`timescale 1ns/1ps
`include "dpsc_params.svh"
// How it works
// - Four 9-bit slots; after reset slot 0 loads the wiper and buffer mode.
// - Buffer mode bit 0 disables the output buffer, 1 enables it.
// - Buffer mode changes only by a slot load; wiper write keeps it.
// - Up and down move the wiper one step and saturate at the ends.
// - Software reset reloads wiper and buffer mode from slot 0.
// - Slot program writes the 9-bit data field into the addressed slot.
// - Save copies wiper and buffer mode into the addressed slot.
// - Slot address bits pick slot 0 to 3 as a binary number.
// - Write lock low blocks every slot change; reads and loads still work.
// - Reads, program, load and save run an access cycle; host waits.
// - Input and output form a 24-bit path; the old word shifts out.
// - Select low frames a command; its rising edge ends it.
// - Input sampled at rising clock; output changes at falling clock.
// - Word is opcode, slot, channel, seven spare bits, data; MSB first.
// - Low eight data bits set the wiper position, one of 256 steps.
// - Serial output returns read data and serves as daisy output.
// - Opcodes decode as the table of thirteen four-bit codes gives.
// - After reset or sleep the part sleeps and takes only wake.
// - First output bit appears at select fall, later bits at falling clock.
module dpsc_core #(
  parameter int ACCESS_CYC = `DPSC_ACCESS_CYC,
  parameter logic [8:0] BOOT_VAL = `DPSC_BOOT_VAL,
  parameter logic [8:0] SLOT_INIT = `DPSC_ERASED
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic sel_n,
  input wire logic serial_in,
  input wire logic write_lock_n,
  output logic serial_out_o,
  output logic serial_out_oe,
  output logic [7:0] wiper_code,
  output logic buffer_enable,
  output logic busy,
  output logic asleep
);
  localparam int CW = $clog2(ACCESS_CYC + 1);
  localparam int BUSY_LAST = ACCESS_CYC - 1;

  logic rst_s1_q, rst_n_q;
  logic sel_s1_q, sel_s2_q, sel_s3_q;
  logic wl_s1_q, wl_s2_q;
  logic seen_q;
  logic asleep_q, asleep_d;
  logic reply_tgl_q;
  logic [`DPSC_WORD_W-1:0] reply_q, reply_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [CW-1:0] busy_len_q, busy_len_d;
  dpsc_pkg::dpsc_state_t state_q, state_d;
  dpsc_pkg::dpsc_setting_t set_q, set_d;
  dpsc_pkg::dpsc_setting_t slot_q [`DPSC_SLOTS];
  dpsc_pkg::dpsc_setting_t pick;
  dpsc_pkg::dpsc_frame_t frame;
  dpsc_pkg::dpsc_cmd_t cmd;
  logic [35:0] slots_flat;
  logic [7:0] up_v, dn_v;
  logic end_ev, fresh, valid_ev, idle, awake_ok, accept, locked;
  logic op_rdw, op_wr, op_rds, op_prog, op_load, op_save, op_up, op_dn;
  logic op_sleep, op_wake, op_erase, op_swrst;
  logic do_prog, do_save, do_erase, boot_ld, access_start, reply_ld;

  function automatic logic is_op(input dpsc_pkg::dpsc_cmd_t c, input logic [3:0] code);
    is_op = c.op == code;
  endfunction

  // Reply word echoes the opcode and slot with the 9-bit value at the bottom.
  function automatic logic [`DPSC_WORD_W-1:0] mk_reply(
    input dpsc_pkg::dpsc_cmd_t c,
    input dpsc_pkg::dpsc_setting_t s
  );
    dpsc_pkg::dpsc_cmd_t r;
    r.op = c.op;
    r.slot = c.slot;
    r.chan = `DPSC_CHAN_ZERO;
    r.pad = `DPSC_PAD_ZERO;
    r.data = s;
    mk_reply = r;
  endfunction

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  dpsc_link u_link (
    .link_clk(link_clk),
    .rst_n(rst_n_q),
    .sel_n(sel_n),
    .serial_in(serial_in),
    .reply(reply_q),
    .reply_tgl(reply_tgl_q),
    .frame(frame),
    .serial_out_o(serial_out_o),
    .serial_out_oe(serial_out_oe)
  );

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
      sel_s3_q <= 1'b1;
      wl_s1_q <= 1'b1;
      wl_s2_q <= 1'b1;
    end else begin
      sel_s1_q <= sel_n;
      sel_s2_q <= sel_s1_q;
      sel_s3_q <= sel_s2_q;
      wl_s1_q <= write_lock_n;
      wl_s2_q <= wl_s1_q;
    end
  end

  // The link clock is still while select is high, so the frame is stable here.
  assign end_ev = sel_s2_q & ~sel_s3_q;
  assign fresh = frame.tgl ^ seen_q;
  assign valid_ev = end_ev & frame.full & fresh;
  assign cmd = frame.word;
  assign idle = state_q == dpsc_pkg::DPSC_IDLE;
  assign awake_ok = ~asleep_q | is_op(cmd, `DPSC_OP_WAKE);
  assign accept = valid_ev & idle & awake_ok;
  assign locked = ~wl_s2_q;

  assign op_rdw = accept & is_op(cmd, `DPSC_OP_RD_WIPER);
  assign op_wr = accept & is_op(cmd, `DPSC_OP_WR_WIPER);
  assign op_rds = accept & is_op(cmd, `DPSC_OP_RD_SLOT);
  assign op_prog = accept & is_op(cmd, `DPSC_OP_PROG);
  assign op_load = accept & is_op(cmd, `DPSC_OP_LOAD);
  assign op_save = accept & is_op(cmd, `DPSC_OP_SAVE);
  assign op_up = accept & is_op(cmd, `DPSC_OP_UP);
  assign op_dn = accept & is_op(cmd, `DPSC_OP_DOWN);
  assign op_sleep = accept & is_op(cmd, `DPSC_OP_SLEEP);
  assign op_wake = accept & is_op(cmd, `DPSC_OP_WAKE);
  assign op_erase = accept & is_op(cmd, `DPSC_OP_ERASE);
  assign op_swrst = accept & is_op(cmd, `DPSC_OP_SWRST);

  assign do_prog = op_prog & ~locked;
  assign do_save = op_save & ~locked;
  assign do_erase = op_erase & ~locked;
  assign access_start = op_rdw | op_rds | do_prog | op_load | do_save;
  assign boot_ld = (state_q == dpsc_pkg::DPSC_BOOT) | op_swrst;
  assign reply_ld = op_rdw | op_rds;

  assign pick = slot_q[cmd.slot];
  assign up_v = (set_q.code == `DPSC_WIPER_MAX) ? set_q.code : set_q.code + 8'h01;
  assign dn_v = (set_q.code == `DPSC_WIPER_MIN) ? set_q.code : set_q.code - 8'h01;

  // Only the slot paths touch the buffer mode bit.
  assign set_d = boot_ld ? slot_q[0] :
    op_load ? pick :
    op_wr ? {set_q.buf_en, cmd.data[7:0]} :
    op_up ? {set_q.buf_en, up_v} :
    op_dn ? {set_q.buf_en, dn_v} :
    set_q;

  assign asleep_d = (boot_ld | op_sleep) ? 1'b1 : (op_wake ? 1'b0 : asleep_q);
  assign reply_d = op_rdw ? mk_reply(cmd, set_q) : mk_reply(cmd, pick);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      dpsc_pkg::DPSC_BOOT: begin
        state_d = dpsc_pkg::DPSC_IDLE;
      end
      dpsc_pkg::DPSC_IDLE: begin
        if (access_start) begin
          state_d = dpsc_pkg::DPSC_BUSY;
          cnt_d = CW'(BUSY_LAST);
        end
      end
      dpsc_pkg::DPSC_BUSY: begin
        if (cnt_q == '0) begin
          state_d = dpsc_pkg::DPSC_IDLE;
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      default: begin
        state_d = dpsc_pkg::DPSC_BOOT;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= dpsc_pkg::DPSC_BOOT;
      cnt_q <= '0;
      set_q <= '0;
      asleep_q <= 1'b1;
      seen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      set_q <= set_d;
      asleep_q <= asleep_d;
      seen_q <= end_ev ? frame.tgl : seen_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reply_q <= '0;
      reply_tgl_q <= 1'b0;
    end else if (reply_ld) begin
      reply_q <= reply_d;
      reply_tgl_q <= ~reply_tgl_q;
    end
  end

  // The slots keep their contents across everything but the hard reset.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < `DPSC_SLOTS; i++) begin
        slot_q[i] <= (i == 0) ? BOOT_VAL : SLOT_INIT;
      end
    end else if (do_prog) begin
      slot_q[cmd.slot] <= cmd.data;
    end else if (do_save) begin
      slot_q[cmd.slot] <= set_q;
    end else if (do_erase) begin
      slot_q[cmd.slot] <= `DPSC_ERASED;
    end
  end

  assign wiper_code = set_q.code;
  assign buffer_enable = set_q.buf_en;
  assign busy = ~idle;
  assign asleep = asleep_q;
  assign slots_flat = {slot_q[3], slot_q[2], slot_q[1], slot_q[0]};

  // Counts the cycles spent in an access so that its length can be checked.
  assign busy_len_d = (state_q == dpsc_pkg::DPSC_BUSY) ? busy_len_q + CW'(1) : '0;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      busy_len_q <= '0;
    end else begin
      busy_len_q <= busy_len_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n_q);

  boot_load_a: assert property (
    state_q == dpsc_pkg::DPSC_BOOT |=> set_q == $past(slot_q[0]) && asleep_q
  ) else $error("Boot did not copy slot 0.");

  buf_mode_a: assert property (
    $changed(set_q.buf_en) |-> $past(op_load || boot_ld)
  ) else $error("Buffer mode changed without a slot load.");

  up_sat_a: assert property (
    op_up |=> set_q.code == (($past(set_q.code) == `DPSC_WIPER_MAX) ?
      `DPSC_WIPER_MAX : $past(set_q.code) + 8'h01)
  ) else $error("Up step wrong.");

  down_sat_a: assert property (
    op_dn |=> set_q.code == (($past(set_q.code) == `DPSC_WIPER_MIN) ?
      `DPSC_WIPER_MIN : $past(set_q.code) - 8'h01)
  ) else $error("Down step wrong.");

  soft_reset_a: assert property (
    op_swrst |=> set_q == $past(slot_q[0]) && asleep_q
  ) else $error("Software reset did not reload slot 0.");

  slot_prog_a: assert property (
    do_prog |=> slot_q[$past(cmd.slot)] == $past(cmd.data)
  ) else $error("Slot program wrote the wrong value.");

  slot_save_a: assert property (
    do_save |=> slot_q[$past(cmd.slot)] == $past(set_q)
  ) else $error("Save wrote the wrong value.");

  lock_hold_a: assert property (
    (accept && locked) |=> $stable(slots_flat)
  ) else $error("Locked slots changed.");

  access_len_a: assert property (
    (state_q == dpsc_pkg::DPSC_BUSY && busy_len_q != CW'(BUSY_LAST)) |=> busy
  ) else $error("Access cycle length wrong.");

  access_go_a: assert property (
    access_start |=> busy
  ) else $error("Access cycle did not start.");

  access_end_a: assert property (
    (state_q == dpsc_pkg::DPSC_BUSY && busy_len_q == CW'(BUSY_LAST)) |=> !busy
  ) else $error("Access cycle ran too long.");

  busy_ignore_a: assert property (
    (valid_ev && state_q == dpsc_pkg::DPSC_BUSY) |=> $stable(set_q) && $stable(slots_flat)
  ) else $error("Command acted while busy.");

  sleep_ignore_a: assert property (
    (valid_ev && asleep_q && !is_op(cmd, `DPSC_OP_WAKE)) |=> $stable(set_q) && asleep_q
  ) else $error("Command acted while asleep.");

  read_reply_a: assert property (
    op_rdw |=> reply_q[8:0] == $past(set_q) && $changed(reply_tgl_q)
  ) else $error("Wiper read reply wrong.");

  erase_val_a: assert property (
    do_erase |=> slot_q[$past(cmd.slot)] == `DPSC_ERASED
  ) else $error("Erase left the slot dirty.");

  wake_clear_a: assert property (
    op_wake |=> !asleep_q
  ) else $error("Wake did not clear sleep.");

  sleep_set_a: assert property (
    op_sleep |=> asleep_q && $stable(set_q)
  ) else $error("Sleep lost the setting.");

  wr_wiper_a: assert property (
    op_wr |=> set_q.code == $past(cmd.data[7:0]) && $stable(set_q.buf_en)
  ) else $error("Wiper write wrong.");

  slot_load_a: assert property (
    op_load |=> set_q == $past(pick)
  ) else $error("Slot load wrong.");

  frame_len_a: assert property (
    (end_ev && !frame.full) |=> $stable(set_q) && $stable(slots_flat) && $stable(asleep_q)
  ) else $error("Short or long frame acted.");

  lock_busy_a: assert property (
    (accept && locked && (is_op(cmd, `DPSC_OP_PROG) || is_op(cmd, `DPSC_OP_SAVE))) |=> !busy
  ) else $error("Locked write started an access.");

  reply_slot_a: assert property (
    op_rds |=> reply_q[8:0] == $past(pick)
  ) else $error("Slot read reply wrong.");

  reply_head_a: assert property (
    reply_ld |=> reply_q[23:20] == $past(cmd.op) && reply_q[19:18] == $past(cmd.slot)
  ) else $error("Reply header wrong.");

  cov_wake_c: cover property (asleep_q ##[1:1000] op_wake);
  cov_load_c: cover property (do_prog ##[1:1000] op_load);
  cov_sat_c: cover property (op_up && set_q.code == `DPSC_WIPER_MAX);
  cov_lock_c: cover property (op_save && locked);
  cov_busy_c: cover property (valid_ev && state_q == dpsc_pkg::DPSC_BUSY);
endmodule // dpsc_core

/* File: src/dpsc_link.sv */
// Link clock side: 24-bit shift path, daisy output and reply loading.
`timescale 1ns/1ps
`include "dpsc_params.svh"
module dpsc_link (
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic sel_n,
  input wire logic serial_in,
  input wire logic [`DPSC_WORD_W-1:0] reply,
  input wire logic reply_tgl,
  output dpsc_pkg::dpsc_frame_t frame,
  output logic serial_out_o,
  output logic serial_out_oe
);
  logic [`DPSC_WORD_W-1:0] shift_q;
  logic [`DPSC_WORD_W-1:0] src;
  logic [`DPSC_CNT_W-1:0] cnt_q;
  logic [`DPSC_CNT_W-1:0] cnt_inc;
  logic ack_q, rs1_q, rs2_q, full_q, tgl_q, sdo_q, msb_q, neg_q;
  logic first, pend, bit_out;

  // The count is cleared while select is high, so a frame starts from zero.
  assign first = cnt_q == '0;
  assign pend = rs2_q ^ ack_q;
  assign src = (first && pend) ? reply : shift_q;
  assign cnt_inc = (cnt_q == `DPSC_CNT_SAT) ? cnt_q : cnt_q + `DPSC_CNT_W'(1);

  always_ff @(posedge link_clk or posedge sel_n) begin
    if (sel_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_inc;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= '0;
      full_q <= 1'b0;
      tgl_q <= 1'b0;
      ack_q <= 1'b0;
      msb_q <= 1'b0;
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      shift_q <= {src[`DPSC_WORD_W-2:0], serial_in};
      full_q <= cnt_inc == `DPSC_CNT_FULL;
      tgl_q <= first ? ~tgl_q : tgl_q;
      ack_q <= (first && pend) ? rs2_q : ack_q;
      msb_q <= first ? src[`DPSC_WORD_W-1] : msb_q;
      rs1_q <= reply_tgl;
      rs2_q <= rs1_q;
    end
  end

  always_ff @(negedge link_clk or posedge sel_n) begin
    if (sel_n) begin
      neg_q <= 1'b0;
    end else begin
      neg_q <= 1'b1;
    end
  end

  always_ff @(negedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= shift_q[`DPSC_WORD_W-1];
    end
  end

  // Until the first falling clock edge the MSB shown at select fall holds.
  assign bit_out = neg_q ? sdo_q : (first ? src[`DPSC_WORD_W-1] : msb_q);
  assign serial_out_o = 1'b0;
  assign serial_out_oe = ~sel_n & ~bit_out;
  assign frame = {shift_q, full_q, tgl_q};
endmodule // dpsc_link

/* File: src/dpsc_params.svh */
// Constants of the digipot serial command core.
`ifndef DPSC_PARAMS_SVH
`define DPSC_PARAMS_SVH
`define DPSC_WORD_W 24
`define DPSC_CNT_W 5
`define DPSC_CNT_SAT 5'h19
`define DPSC_CNT_FULL 5'h18
`define DPSC_SLOTS 4
`define DPSC_OP_NOP 4'h0
`define DPSC_OP_RD_WIPER 4'hC
`define DPSC_OP_WR_WIPER 4'h4
`define DPSC_OP_RD_SLOT 4'hA
`define DPSC_OP_PROG 4'h2
`define DPSC_OP_LOAD 4'hB
`define DPSC_OP_SAVE 4'h3
`define DPSC_OP_UP 4'h7
`define DPSC_OP_DOWN 4'hF
`define DPSC_OP_SLEEP 4'h8
`define DPSC_OP_WAKE 4'h1
`define DPSC_OP_ERASE 4'hD
`define DPSC_OP_SWRST 4'h9
`define DPSC_CHAN_ZERO 2'h0
`define DPSC_PAD_ZERO 7'h00
`define DPSC_ERASED 9'h1FF
`define DPSC_BOOT_VAL 9'h080
`define DPSC_WIPER_MAX 8'hFF
`define DPSC_WIPER_MIN 8'h00
`define DPSC_CLK_NS 4
`define DPSC_ACCESS_NS 1000
`define DPSC_ACCESS_CYC ((`DPSC_ACCESS_NS + `DPSC_CLK_NS - 1) / `DPSC_CLK_NS)
`endif

/* File: src/dpsc_pkg.sv */
// Types shared by the digipot serial command core.
package dpsc_pkg;
  typedef enum logic [1:0] {
    DPSC_BOOT = 2'b00,
    DPSC_IDLE = 2'b01,
    DPSC_BUSY = 2'b11
  } dpsc_state_t;
  typedef struct packed {
    logic [3:0] op;
    logic [1:0] slot;
    logic [1:0] chan;
    logic [6:0] pad;
    logic [8:0] data;
  } dpsc_cmd_t;
  typedef struct packed {
    logic buf_en;
    logic [7:0] code;
  } dpsc_setting_t;
  typedef struct packed {
    dpsc_cmd_t word;
    logic full;
    logic tgl;
  } dpsc_frame_t;
endpackage

/* File: testbench/dpsc_core_tb_top.sv */
// Self-checking testbench of the digipot serial command core.
`timescale 1ns/1ps
`include "dpsc_params.svh"
module dpsc_core_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic write_lock_n = 1'b1;
  logic sel_n, link_clk, serial_in, sdo_o, sdo_oe, sdo_line, busy, asleep, buffer_enable;
  logic [7:0] wiper_code, ew, v;
  logic [8:0] sl [4];
  logic [3:0] lops [3];
  logic eb, awake, lk;
  int failures = 0;
  int check_count = 0;
  int seed = 16;
  int i;
  always #2 clk = ~clk;
  assign sdo_line = sdo_oe ? sdo_o : 1'b1;
  dpsc_host i_dpsc_host (.sel_n(sel_n), .link_clk(link_clk), .serial_in(serial_in),
    .sdo_line(sdo_line));
  dpsc_core #(.ACCESS_CYC(1200)) i_dpsc_core (.clk(clk), .rst_b(rst_b), .link_clk(link_clk),
    .sel_n(sel_n), .serial_in(serial_in), .write_lock_n(write_lock_n), .serial_out_o(sdo_o),
    .serial_out_oe(sdo_oe), .wiper_code(wiper_code), .buffer_enable(buffer_enable),
    .busy(busy), .asleep(asleep));
  function automatic logic [7:0] step(input logic [7:0] w, input logic up);
    if (up) return (w == `DPSC_WIPER_MAX) ? w : w + 8'h01;
    return (w == `DPSC_WIPER_MIN) ? w : w - 8'h01;
  endfunction
  function automatic logic acc(input logic [3:0] o, input int n);
    logic a;
    a = o inside {`DPSC_OP_RD_WIPER, `DPSC_OP_RD_SLOT, `DPSC_OP_PROG, `DPSC_OP_LOAD,
      `DPSC_OP_SAVE};
    if (lk && o inside {`DPSC_OP_PROG, `DPSC_OP_SAVE}) a = 1'b0;
    return a && awake && n == 24;
  endfunction
  task automatic results;
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] s);
    check_count++;
    if (e !== s) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic st;
    chk("wiper", ew, wiper_code);
    chk("buffer", eb, buffer_enable);
  endtask
  task automatic cmd(input logic [3:0] o, input logic [1:0] s, input logic [8:0] d,
    input int n = 24);
    int k;
    logic b;
    b = acc(o, n);
    i_dpsc_host.frame({o, s, `DPSC_CHAN_ZERO, `DPSC_PAD_ZERO, d}, n);
    if (n == 24 && o == `DPSC_OP_WAKE) awake = 1'b1;
    else if (n == 24 && awake && o inside {`DPSC_OP_SLEEP, `DPSC_OP_SWRST}) awake = 1'b0;
    repeat (8) @(posedge clk);
    chk("busy", b, busy);
    chk("asleep", !awake, asleep);
    for (k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge clk);
    if (k == 2000) chk("busy_end", 1'b0, 1'b1);
    repeat (10) @(posedge clk);
  endtask
  initial begin
    #380000;
    failures++;
    results();
  end
  initial begin
    sl = '{`DPSC_BOOT_VAL, `DPSC_ERASED, `DPSC_ERASED, `DPSC_ERASED};
    lops = '{`DPSC_OP_ERASE, `DPSC_OP_PROG, `DPSC_OP_SAVE};
    {eb, ew} = `DPSC_BOOT_VAL;
    awake = 1'b0;
    lk = 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk);
    chk("asleep", 1'b1, asleep);
    st();
    cmd(`DPSC_OP_UP, 2'h0, 9'h000);
    st();
    cmd(`DPSC_OP_WAKE, 2'h0, 9'h000);
    for (i = 0; i < 6; i++) begin
      v = (i < 2) ? 8'hFF : (i < 4) ? 8'h00 : 8'($random(seed));
      cmd(`DPSC_OP_WR_WIPER, 2'h0, {1'b1, v});
      ew = v;
      st();
      cmd(i[0] ? `DPSC_OP_DOWN : `DPSC_OP_UP, 2'h0, 9'h000);
      ew = step(ew, !i[0]);
      st();
    end
    cmd(`DPSC_OP_NOP, 2'h3, 9'h155);
    cmd(`DPSC_OP_NOP, 2'h0, 9'h000);
    chk("daisy", {`DPSC_OP_NOP, 2'h3, 2'h0, 7'h00, 9'h155}, i_dpsc_host.rx);
    i_dpsc_host.frame({`DPSC_OP_WR_WIPER, 2'h0, 2'h0, 7'h00, 9'h0C3,
      `DPSC_OP_NOP, 2'h2, 2'h0, 7'h00, 9'h03C}, 48);
    chk("chain_far", {`DPSC_OP_WR_WIPER, 2'h0, 2'h0, 7'h00, 9'h0C3}, i_dpsc_host.rx);
    cmd(`DPSC_OP_NOP, 2'h0, 9'h000);
    chk("chain_near", {`DPSC_OP_NOP, 2'h2, 2'h0, 7'h00, 9'h03C}, i_dpsc_host.rx);
    st();
    for (i = 0; i < 4; i++) begin
      cmd(`DPSC_OP_ERASE, i[1:0], 9'h000);
      sl[i] = {i[0], 8'($random(seed))};
      cmd(`DPSC_OP_PROG, i[1:0], sl[i]);
    end
    for (i = 3; i >= 0; i--) begin
      cmd(`DPSC_OP_LOAD, i[1:0], 9'h000);
      {eb, ew} = sl[i];
      st();
    end
    cmd(`DPSC_OP_LOAD, 2'h1, 9'h000);
    {eb, ew} = sl[1];
    v = 8'($random(seed));
    cmd(`DPSC_OP_WR_WIPER, 2'h0, {1'b0, v});
    ew = v;
    cmd(`DPSC_OP_ERASE, 2'h2, 9'h000);
    i_dpsc_host.frame({`DPSC_OP_SAVE, 2'h2, 2'h0, 7'h00, 9'h000}, 24);
    i_dpsc_host.frame({`DPSC_OP_UP, 2'h0, 2'h0, 7'h00, 9'h000}, 24);
    cmd(`DPSC_OP_NOP, 2'h0, 9'h000);
    st();
    sl[2] = {eb, ew};
    cmd(`DPSC_OP_LOAD, 2'h0, 9'h000);
    cmd(`DPSC_OP_LOAD, 2'h2, 9'h000);
    st();
    for (i = 0; i < 2; i++) begin
      cmd(i[0] ? `DPSC_OP_RD_WIPER : `DPSC_OP_RD_SLOT, 2'h1, 9'h000);
      cmd(`DPSC_OP_NOP, 2'h0, 9'h000);
      cmd(`DPSC_OP_NOP, 2'h0, 9'h000);
      chk("reply", {i[0] ? `DPSC_OP_RD_WIPER : `DPSC_OP_RD_SLOT, 2'h1, 2'h0, 7'h00,
        i[0] ? {eb, ew} : sl[1]}, i_dpsc_host.rx);
    end
    write_lock_n <= 1'b0;
    lk = 1'b1;
    for (i = 0; i < 3; i++) cmd(lops[i], 2'h3, 9'h0AA);
    cmd(`DPSC_OP_LOAD, 2'h3, 9'h000);
    {eb, ew} = sl[3];
    st();
    write_lock_n <= 1'b1;
    lk = 1'b0;
    for (i = 23; i <= 25; i += 2) begin
      cmd(`DPSC_OP_WR_WIPER, 2'h0, 9'h033, i);
      st();
    end
    cmd(`DPSC_OP_SLEEP, 2'h0, 9'h000);
    cmd(`DPSC_OP_WR_WIPER, 2'h0, 9'h011);
    st();
    cmd(`DPSC_OP_WAKE, 2'h0, 9'h000);
    cmd(`DPSC_OP_WR_WIPER, 2'h0, 9'h05A);
    cmd(`DPSC_OP_SWRST, 2'h0, 9'h000);
    {eb, ew} = sl[0];
    st();
    results();
  end
endmodule // dpsc_core_tb_top

/* File: testbench/dpsc_host.sv */
// Host model: drives command frames on the serial link and captures serial_out.
`timescale 1ns/1ps
module dpsc_host (
  output logic sel_n,
  output logic link_clk,
  output logic serial_in,
  input wire logic sdo_line
);
  logic [23:0] rx;
  initial begin
    sel_n = 1'b1;
    link_clk = 1'b0;
    serial_in = 1'b0;
    rx = 24'h000000;
  end
  // The link clock stands still outside frames.
  // A 48-bit frame sends the far word in the upper half first.
  task automatic frame(input logic [47:0] w, input int n);
    int k;
    #1;
    sel_n = 1'b0;
    #40;
    for (k = 0; k < n; k++) begin
      serial_in = w[(n == 48 && k < 24) ? 47 - k : 23 - (k % 24)];
      #80 link_clk = 1'b1;
      rx = {rx[22:0], sdo_line};
      #80 link_clk = 1'b0;
    end
    #40 serial_in = ~serial_in;
    sel_n = 1'b1;
    #100;
  endtask
endmodule // dpsc_host
